/* File: pmsf_match.sv */
// module: table lookup of a source address, one compare per entry
`timescale 1ns/1ns
module pmsf_match
  import pmsf_pkg::*;
(
  input  pmsf_ent_t [TBL_DEPTH-1:0] tbl,
  input  wire logic [47:0]          mac,
  output logic                      hit,
  output logic [TW-1:0]             hit_idx,
  output logic                      free,
  output logic [TW-1:0]             free_idx
);

  logic [TBL_DEPTH-1:0] eq;
  logic [TBL_DEPTH-1:0] empty;

  // ****************************************************************
  // per entry compare
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < TBL_DEPTH; g++) begin : g_cmp
      assign eq[g]    = tbl[g].valid && (tbl[g].mac == mac);
      assign empty[g] = !tbl[g].valid;
    end
  endgenerate

  always_comb begin
    hit      = 1'b0;
    hit_idx  = '0;
    free     = 1'b0;
    free_idx = '0;
    for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
      if (eq[i]) begin
        hit     = 1'b1;
        hit_idx = TW'(i);
      end
      if (empty[i]) begin
        free     = 1'b1;
        free_idx = TW'(i);
      end
    end
  end

endmodule

/* File: pmsf_pkg.sv */
// package: constants and types for the port mac security filter
// Operation
// - secured port forwards only table-matched sources
// - secured port drops unmatched source frames
// - unsecured port forwards every frame
// - learn only when port active and learning
// - cap dynamic learned count at port limit
// - limit range 0..16384, zero means unlimited
// - freeze turns listed ports' dynamic entries static
// - freeze sets secure, clears learn, listed ports
// - global enable gates whole security function; the code still applies port limits and freeze with it off
// - all-ports write copies into every port
// - working settings volatile until explicit save
// - shared table holds at most 32K entries
package pmsf_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NPORTS     = 8;
  localparam int PW         = 3;
  localparam int TBL_DEPTH  = 16;
  localparam int TW         = 4;
  localparam int LIM_W      = 15;
  localparam int CNT_W      = 16;
  localparam logic [LIM_W-1:0] LIMIT_MAX   = 15'h4000;
  localparam logic [CNT_W-1:0] TOTAL_MAX   = 16'h8000;
  localparam logic [7:0]       AGE_RESET   = 8'hff;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] A_GLOBAL  = 8'h00;
  localparam logic [7:0] A_ALLPORT = 8'h04;
  localparam logic [7:0] A_FREEZE  = 8'h08;
  localparam logic [7:0] A_SAVE    = 8'h0c;
  localparam logic [7:0] A_STATUS  = 8'h10;
  localparam logic [7:0] A_PORT0   = 8'h20;
  localparam logic [7:0] A_CNT0    = 8'h40;

  // port config word fields
  localparam int F_SEC   = 0;
  localparam int F_LEARN = 1;
  localparam int F_LIM   = 16;

  typedef struct packed {
    logic             secure;
    logic             learn;
    logic [LIM_W-1:0] limit;
  } pmsf_cfg_t;

  localparam pmsf_cfg_t CFG_RESET = '{secure: 1'b0, learn: 1'b1,
                                      limit: 15'h0000};

  typedef struct packed {
    logic          valid;
    logic          stat;
    logic [PW-1:0] port;
    logic [47:0]   mac;
    logic [7:0]    age;
  } pmsf_ent_t;

  typedef struct packed {
    logic          valid;
    logic [PW-1:0] port;
    logic          link_up;
    logic [47:0]   mac;
  } pmsf_frm_t;

  typedef enum logic [1:0] {FRZ_IDLE, FRZ_WALK} pmsf_frz_t;

endpackage

/* File: pmsf_station.sv */
// model: stations sending frames into switch ports
`timescale 1ns/1ns
module pmsf_station
  import pmsf_pkg::*;
(
  input wire logic ref_clk,
  output pmsf_frm_t frm
);
  initial begin
    frm = '0;
  end
  // *****
  // one frame, then inverted idle lines
  // *****
  task automatic send(input logic [PW-1:0] p, input logic l,
                      input logic [47:0] m);
    @(posedge ref_clk);
    frm <= '{valid: 1'b1, port: p, link_up: l, mac: m};
    @(posedge ref_clk);
    frm <= '{valid: 1'b0, port: ~p, link_up: ~l, mac: ~m};
  endtask
endmodule

/* File: pmsf_sva.sv */
// checker: port-level properties of the security filter
`timescale 1ns/1ns
module pmsf_sva
  import pmsf_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input pmsf_frm_t        frm_in,
  input wire logic        fwd_q,
  input wire logic        drop_q,
  input wire logic        save_req_q
);
  // *****
  // write tracking
  // *****
  logic       wa_q;
  logic [7:0] wad_q;
  logic       glob_q;
  logic       sv_wr;
  always_ff @(posedge ref_clk) begin
    wa_q  <= hsel & hready & htrans[1] & hwrite & !rst;
    wad_q <= haddr[7:0];
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      glob_q <= 1'b0;
    end else if (wa_q && wad_q == A_GLOBAL) begin
      glob_q <= hwdata[0];
    end
  end
  assign sv_wr = wa_q && wad_q == A_SAVE && hwdata[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_save_wr;
    sv_wr;
  endsequence
  sequence s_verdict;
    fwd_q ^ drop_q;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  a_one_verdict: assert property (frm_in.valid |=> s_verdict)
    else $error("frame without single verdict");
  a_no_stray: assert property (!frm_in.valid |=> !fwd_q && !drop_q)
    else $error("verdict without frame");
  a_open_fwd: assert property (frm_in.valid && !glob_q |=> fwd_q)
    else $error("frame dropped with global off");
  a_save_cause: assert property (s_save_wr |=> save_req_q)
    else $error("save write without request");
  a_save_needs: assert property (save_req_q |-> $past(sv_wr))
    else $error("save request without write");
  a_reset_quiet: assert property (@(posedge ref_clk) disable iff (1'b0)
    rst |=> !fwd_q && !drop_q && !save_req_q)
    else $error("outputs active after reset");
endmodule
bind pmsf_top pmsf_sva chk_u (.ref_clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .frm_in, .fwd_q,
  .drop_q, .save_req_q);

/* File: pmsf_top.sv */
// module: per-port source address admission filter with ahb-lite regs
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module pmsf_top
  import pmsf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  pmsf_frm_t        frm_in,
  input  wire logic        age_tick,
  output logic             fwd_q,
  output logic             drop_q,
  output logic             save_req_q
);

  // ****************************************************************
  // state
  // ****************************************************************
  pmsf_cfg_t [NPORTS-1:0]    cfg_q;
  pmsf_cfg_t                 all_q;
  logic                      gen_q;
  pmsf_ent_t [TBL_DEPTH-1:0] tbl_q;
  logic [CNT_W-1:0]          cnt_q [NPORTS];
  logic [CNT_W-1:0]          total_q;
  logic [NPORTS-1:0]         frz_list_q;
  pmsf_frz_t                 frz_q;
  logic [TW-1:0]             frz_idx_q;
  logic                      ap_wr_q;
  logic [7:0]                ap_addr_q;
  logic [31:0]               rdata_d;

  logic                      hit;
  logic [TW-1:0]             hit_idx;
  logic                      free;
  logic [TW-1:0]             free_idx;

  pmsf_match u_match (
    .tbl      (tbl_q),
    .mac      (frm_in.mac),
    .hit      (hit),
    .hit_idx  (hit_idx),
    .free     (free),
    .free_idx (free_idx)
  );

  // ****************************************************************
  // ahb-lite slave, zero wait states
  // ****************************************************************
  wire ap_ok = hsel && hready && htrans[1];
  wire wr_go = ap_wr_q;
  wire [31:0] wd = hwdata;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q <= ap_ok && hwrite;
      if (ap_ok) begin
        ap_addr_q <= haddr[7:0];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (haddr[7:0] == A_GLOBAL) begin
      rdata_d = {31'h0, gen_q};
    end else if (haddr[7:0] == A_ALLPORT) begin
      rdata_d = {1'b0, all_q.limit, 14'h0, all_q.learn, all_q.secure};
    end else if (haddr[7:0] == A_FREEZE) begin
      rdata_d = {23'h0, frz_q == FRZ_WALK, frz_list_q};
    end else if (haddr[7:0] == A_STATUS) begin
      rdata_d = {16'h0, total_q};
    end else if (haddr[7:5] == A_PORT0[7:5] &&
                 haddr[1:0] == 2'b00) begin
      rdata_d = {1'b0, cfg_q[haddr[4:2]].limit, 14'h0,
                 cfg_q[haddr[4:2]].learn, cfg_q[haddr[4:2]].secure};
    end else if (haddr[7:5] == A_CNT0[7:5] &&
                 haddr[1:0] == 2'b00) begin
      rdata_d = {16'h0, cnt_q[haddr[4:2]]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_ok && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  // clamp a written limit into range
  function automatic logic [LIM_W-1:0] clamp_lim(input logic [14:0] v);
    clamp_lim = (v > LIMIT_MAX) ? LIMIT_MAX : v;
  endfunction

  wire port_wr = wr_go && ap_addr_q[7:5] == A_PORT0[7:5] &&
                 ap_addr_q[1:0] == 2'b00;
  wire [PW-1:0] wr_port = ap_addr_q[4:2];
  wire frz_start = wr_go && ap_addr_q == A_FREEZE && frz_q == FRZ_IDLE;

  // ****************************************************************
  // global enable and save request
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gen_q      <= 1'b0;
      save_req_q <= 1'b0;
    end else begin
      if (wr_go && ap_addr_q == A_GLOBAL) begin
        gen_q <= wd[0];
      end
      save_req_q <= wr_go && ap_addr_q == A_SAVE && wd[0];
    end
  end

  // ****************************************************************
  // port configuration
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      all_q <= CFG_RESET;
      for (int p = 0; p < NPORTS; p++) begin
        cfg_q[p] <= CFG_RESET;
      end
    end else begin
      if (wr_go && ap_addr_q == A_ALLPORT) begin
        all_q.secure <= wd[F_SEC];
        all_q.learn  <= wd[F_LEARN];
        all_q.limit  <= clamp_lim(wd[F_LIM +: LIM_W]);
        for (int p = 0; p < NPORTS; p++) begin
          cfg_q[p].secure <= wd[F_SEC];
          cfg_q[p].learn  <= wd[F_LEARN];
          cfg_q[p].limit  <= clamp_lim(wd[F_LIM +: LIM_W]);
        end
      end else if (port_wr) begin
        cfg_q[wr_port].secure <= wd[F_SEC];
        cfg_q[wr_port].learn  <= wd[F_LEARN];
        cfg_q[wr_port].limit  <= clamp_lim(wd[F_LIM +: LIM_W]);
      end else if (frz_start) begin
        for (int p = 0; p < NPORTS; p++) begin
          if (wd[p]) begin
            cfg_q[p].secure <= 1'b1;
            cfg_q[p].learn  <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // admission decision
  // ****************************************************************
  wire [PW-1:0] fp = frm_in.port;
  wire sec_on = gen_q && cfg_q[fp].secure;
  wire lrn_on = !gen_q || cfg_q[fp].learn;
  wire own_hit = hit && tbl_q[hit_idx].port == fp;
  wire lim_ok = cfg_q[fp].limit == '0 ||
                cnt_q[fp] < CNT_W'(cfg_q[fp].limit);
  wire can_learn = frm_in.valid && frm_in.link_up && lrn_on && !hit &&
                   free && lim_ok && total_q < TOTAL_MAX &&
                   frz_q == FRZ_IDLE;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fwd_q  <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      fwd_q  <= 1'b0;
      drop_q <= 1'b0;
      if (frm_in.valid) begin
        if (!sec_on) begin
          fwd_q <= 1'b1;
        end else if (own_hit) begin
          fwd_q <= 1'b1;
        end else begin
          drop_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // address table, aging and freeze walk
  // ****************************************************************
  logic [NPORTS-1:0]    inc_p;
  logic [TW:0]          dec_n [NPORTS];
  logic [TBL_DEPTH-1:0] aged;
  logic [TBL_DEPTH-1:0] frz_rm;

  genvar g;
  generate
    for (g = 0; g < TBL_DEPTH; g++) begin : g_age
      assign aged[g] = age_tick && tbl_q[g].valid && !tbl_q[g].stat &&
                       tbl_q[g].age == 8'h00;
      assign frz_rm[g] = frz_q == FRZ_WALK && frz_idx_q == TW'(g) &&
                         tbl_q[g].valid && !tbl_q[g].stat && !aged[g] &&
                         frz_list_q[tbl_q[g].port];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tbl_q <= '0;
    end else begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        if (aged[i]) begin
          tbl_q[i].valid <= 1'b0;
        end else if (age_tick && tbl_q[i].valid && !tbl_q[i].stat) begin
          tbl_q[i].age <= tbl_q[i].age - 8'h01;
        end
      end
      if (hit && frm_in.valid && !tbl_q[hit_idx].stat) begin
        tbl_q[hit_idx].age <= AGE_RESET;
      end
      if (can_learn) begin
        tbl_q[free_idx] <= '{valid: 1'b1, stat: 1'b0, port: fp,
                             mac: frm_in.mac, age: AGE_RESET};
      end
      if (frz_q == FRZ_WALK && tbl_q[frz_idx_q].valid &&
          frz_list_q[tbl_q[frz_idx_q].port]) begin
        tbl_q[frz_idx_q].stat <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frz_q      <= FRZ_IDLE;
      frz_idx_q  <= '0;
      frz_list_q <= '0;
    end else begin
      case (frz_q)
        FRZ_IDLE: begin
          if (frz_start) begin
            frz_list_q <= wd[NPORTS-1:0];
            frz_idx_q  <= '0;
            frz_q      <= FRZ_WALK;
          end
        end
        FRZ_WALK: begin
          frz_idx_q <= frz_idx_q + 1'b1;
          if (frz_idx_q == TW'(TBL_DEPTH - 1)) begin
            frz_q <= FRZ_IDLE;
          end
        end
        default: frz_q <= FRZ_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // learned counters
  // ****************************************************************
  always_comb begin
    inc_p = '0;
    if (can_learn) begin
      inc_p[fp] = 1'b1;
    end
  end

  // ****************************************************************
  // removal counts per port
  // ****************************************************************
  // several entries of one port may leave in one cycle
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      dec_n[p] = '0;
      for (int i = 0; i < TBL_DEPTH; i++) begin
        if ((aged[i] || frz_rm[i]) && tbl_q[i].port == PW'(p)) begin
          dec_n[p] = dec_n[p] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int p = 0; p < NPORTS; p++) begin
        cnt_q[p] <= '0;
      end
      total_q <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        // aged and freeze decrement
        // saturate at zero on a stray removal
        if (cnt_q[p] + CNT_W'(inc_p[p]) >= CNT_W'(dec_n[p])) begin
          cnt_q[p] <= cnt_q[p] + CNT_W'(inc_p[p]) - CNT_W'(dec_n[p]);
        end else begin
          cnt_q[p] <= '0;
        end
      end
      total_q <= total_q + CNT_W'(can_learn) -
                 CNT_W'($countones(aged));
    end
  end

endmodule

/* File: pmsf_top_tb_top.sv */
// bench: self-checking top for the security filter
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin \
  error_cnt++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module pmsf_top_tb_top
  import pmsf_pkg::*;
();
  logic        ref_clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        age_tick;
  logic        hreadyout;
  logic        hresp;
  logic        fwd_q;
  logic        drop_q;
  logic        save_req_q;
  logic [1:0]  htrans;
  logic [1:0]  ev;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [47:0] rm;
  pmsf_frm_t   frm_in;
  int          error_cnt = 0;
  int          compares = 0;
  int          seed;
  int          i;
  logic [1:0]  exp_q[$];
  localparam logic [47:0] MA = 48'h0200_0000_00a1;
  localparam logic [47:0] MB = 48'h0200_0000_00b2;
  localparam logic [47:0] MC = 48'h0200_0000_00c3;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  pmsf_top dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frm_in(frm_in),
    .age_tick(age_tick), .fwd_q(fwd_q), .drop_q(drop_q),
    .save_req_q(save_req_q));
  pmsf_station stn_u (.ref_clk(ref_clk), .frm(frm_in));
  // *****
  // result watcher: 0 drop, 1 forward, 2 save
  // *****
  always @(posedge ref_clk) begin
    if (fwd_q === 1'b1 || drop_q === 1'b1 || save_req_q === 1'b1) begin
      ev = (exp_q.size() != 0) ? exp_q.pop_front() : 2'h3;
      `CHK("verdict", ev, {save_req_q, fwd_q})
    end
  end
  task automatic conclude();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wt();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wt();
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("rdata", e, r)
  endtask
  task automatic fr(input logic [2:0] p, input logic l,
                    input logic [47:0] m, input logic [1:0] e);
    exp_q.push_back(e);
    stn_u.send(p, l, m);
  endtask
  task automatic ages(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      age_tick <= 1'b1;
      @(posedge ref_clk);
      age_tick <= 1'b0;
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
  initial begin
    seed = 9;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    age_tick = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(A_PORT0, 32'h0000_0002);
    rd(A_GLOBAL, 32'h0);
    rd(8'h80, 32'h0);
    bus(1'b1, A_ALLPORT, 32'h0002_0003);
    rd(A_PORT0 + 8'h14, 32'h0002_0003);
    fr(3'd0, 1'b1, MA, 2'd1);
    fr(3'd0, 1'b1, MB, 2'd1);
    fr(3'd0, 1'b1, MC, 2'd1);
    rd(A_CNT0, 32'h2);
    rd(A_STATUS, 32'h2);
    bus(1'b1, A_GLOBAL, 32'h1);
    fr(3'd0, 1'b1, MA, 2'd1);
    fr(3'd0, 1'b1, MB, 2'd1);
    fr(3'd0, 1'b1, MC, 2'd0);
    fr(3'd7, 1'b1, MA, 2'd0);
    bus(1'b1, A_PORT0 + 8'h04, 32'h0002_0001);
    fr(3'd1, 1'b1, MB, 2'd0);
    fr(3'd1, 1'b1, MB, 2'd0);
    rd(A_CNT0 + 8'h04, 32'h0);
    fr(3'd2, 1'b0, MC, 2'd0);
    rd(A_CNT0 + 8'h08, 32'h0);
    bus(1'b1, A_PORT0 + 8'h10, 32'h0);
    for (i = 0; i < 8; i++) begin
      rm = 48'({$random(seed), $random(seed)});
      fr(3'd4, 1'b1, rm, 2'd1);
    end
    ages(260);
    rd(A_CNT0, 32'h0);
    fr(3'd0, 1'b1, MC, 2'd0);
    rd(A_CNT0, 32'h1);
    fr(3'd0, 1'b1, MC, 2'd1);
    bus(1'b1, A_FREEZE, 32'h01);
    for (i = 0; i < 40; i++) begin
      bus(1'b0, A_FREEZE, 32'h0);
      if (r[8] === 1'b0) break;
    end
    `CHK("busy", 1'b0, r[8])
    rd(A_PORT0, 32'h0002_0001);
    rd(A_PORT0 + 8'h08, 32'h0002_0003);
    rd(A_CNT0, 32'h0);
    ages(260);
    fr(3'd0, 1'b1, MC, 2'd1);
    exp_q.push_back(2'd2);
    bus(1'b1, A_SAVE, 32'h1);
    bus(1'b1, A_ALLPORT, 32'h7fff_0002);
    rd(A_PORT0 + 8'h18, 32'h4000_0002);
    repeat (4) @(posedge ref_clk);
    `CHK("pending", 0, exp_q.size())
    conclude();
  end
endmodule
